// *** design/bd_defs.vh ***
/*
 Shared constants of the capacity bar display: register map, field
 positions, reset values, charge thresholds and timing figures.
 Assumes it is included once per file by its bare name.
*/
`ifndef BD_DEFS_VH
`define BD_DEFS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define BD_ADR_CHARGE      8'h00
`define BD_ADR_CAPACITY    8'h04
`define BD_ADR_FLAGS       8'h08
`define BD_ADR_STATUS      8'h0C
`define BD_ADR_FULLREF     8'h10
`define BD_ADR_SELREF      8'h14
`define BD_ADR_PACKCFG     8'h28

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BD_CFG_ABS_BIT     0
`define BD_CFG_SEG_LO      1
`define BD_CFG_SEG_HI      2
`define BD_FLG_EOD_BIT     0
`define BD_ST_ACTIVE_BIT   0
`define BD_ST_LOWCAP_BIT   1
`define BD_ST_PHASE_BIT    2
`define BD_ST_EOD_BIT      3
`define BD_ST_LED_LO       4
`define BD_ST_LED_HI       8

// ------------------------------------------------------------
// Segment count codes
// ------------------------------------------------------------
`define BD_SEG_THREE       2'h0
`define BD_SEG_FOUR        2'h1
`define BD_SEG_FIVE        2'h2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BD_RST_PACKCFG     32'h00000004
`define BD_RST_WORD        32'h00000000

// ------------------------------------------------------------
// Charge thresholds in percent
// ------------------------------------------------------------
`define BD_P5_1            8'h14
`define BD_P5_2            8'h28
`define BD_P5_3            8'h3C
`define BD_P5_4            8'h50
`define BD_P4_1            8'h19
`define BD_P4_2            8'h32
`define BD_P4_3            8'h4B
`define BD_P3_1            8'h22
`define BD_P3_2            8'h43

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BD_CLK_KHZ         100000
`define BD_DISPLAY_REQUEST_INPUT_TIME_MS    4000
`define BD_BLINK_TIME_MS   500

`endif

// *** design/bd_pin_sync.v ***
/*
 Three-stage synchroniser for one pin. The output moves only once the
 second and third stages agree, which also rejects one-cycle glitches.
 Assumes the pin is asynchronous to clk and idles high.
*/
`default_nettype none

module bd_pin_sync (
   // Clock and reset
   input  wire clk,
   input  wire rst_n,
   // Pin and its clean level
   input  wire pinIn,
   output reg  levelOut
);

   reg stage1_ff;
   reg stage2_ff;
   reg stage3_ff;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= 1'b1;
         stage2_ff <= 1'b1;
         stage3_ff <= 1'b1;
         levelOut  <= 1'b1;
      end else begin
         stage1_ff <= pinIn;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         if (stage2_ff == stage3_ff) begin
            levelOut <= stage3_ff;
         end
      end
   end

endmodule // bd_pin_sync

`default_nettype wire

// *** design/bd_bar_display.v ***
/*
 Capacity bar display: drives three, four or five LED segments from the
 state of charge, started by a push on an active-low request pin.
 Assumes a classic Wishbone master and a gauge core that writes charge
 figures and the end-of-discharge flag into the registers.
*/
`default_nettype none
`include "bd_defs.vh"

module bd_bar_display #(
   parameter DISPLAY_REQUEST_INPUT_CYCLES  = `BD_DISPLAY_REQUEST_INPUT_TIME_MS * `BD_CLK_KHZ,
   parameter BLINK_CYCLES = `BD_BLINK_TIME_MS * `BD_CLK_KHZ,
   parameter TMR_W        = 29,
   parameter SEG_MAX      = 5
) (
   // Clock and reset
   input  wire                clk,
   input  wire                rst_n,
   // Wishbone slave
   input  wire                wb_cyc_i,
   input  wire                wb_stb_i,
   input  wire                wb_we_i,
   input  wire [7:0]          wb_adr_i,
   input  wire [3:0]          wb_sel_i,
   input  wire [31:0]         wb_dat_i,
   output reg  [31:0]         wb_dat_o,
   output reg                 wb_ack_o,
   // Pushbutton, active low
   input  wire                displayRequest_n,
   // LED segments, high lights a segment
   output reg  [SEG_MAX-1:0]  ledSeg
);

   // Computed at 32 bits, then cut on purpose to the timer width
   localparam [31:0]      DISPLAY_REQUEST_INPUT_LAST32  = DISPLAY_REQUEST_INPUT_CYCLES - 1;
   localparam [31:0]      BLINK_LAST32 = BLINK_CYCLES - 1;
   localparam [TMR_W-1:0] DISPLAY_REQUEST_INPUT_LAST    = DISPLAY_REQUEST_INPUT_LAST32[TMR_W-1:0];
   localparam [TMR_W-1:0] BLINK_LAST   = BLINK_LAST32[TMR_W-1:0];

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [31:0]      packCfg_ff;
   reg  [31:0]      charge_ff;
   reg  [31:0]      capacity_ff;
   reg  [31:0]      flags_ff;
   reg  [31:0]      fullRef_ff;
   reg              reqLevel_ff;
   reg              active_ff;
   reg  [TMR_W-1:0] dispTmr_ff;
   reg  [TMR_W-1:0] blinkTmr_ff;
   reg              blinkPhase_ff;

   wire             reqLevel;
   wire             busReq;
   wire             busWr;
   reg  [31:0]      nxt_rdData;
   reg  [SEG_MAX-1:0] nxt_ledSeg;
   reg  [2:0]       litCount;
   reg  [7:0]       percent;
   reg  [15:0]      refCapacity;
   wire             absMode;
   wire [1:0]       segCode;
   wire [15:0]      remCap;
   wire [15:0]      lowThr;
   wire             eodFlag;
   wire             lowCap;
   wire             fallEdge;

   // ------------------------------------------------------------
   // Field views
   // ------------------------------------------------------------
   assign absMode = packCfg_ff[`BD_CFG_ABS_BIT];
   assign segCode = packCfg_ff[`BD_CFG_SEG_HI:`BD_CFG_SEG_LO];
   assign remCap  = capacity_ff[15:0];
   assign lowThr  = capacity_ff[31:16];
   assign eodFlag = flags_ff[`BD_FLG_EOD_BIT];
   assign lowCap  = (remCap < lowThr);

   // ------------------------------------------------------------
   // Byte-lane merge
   // ------------------------------------------------------------
   function [31:0] merge;
      input [31:0] oldVal;
      input [31:0] newVal;
      input [3:0]  sel;
      integer      i;
      begin
         merge = oldVal;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = newVal[i*8 +: 8];
            end
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   // One wait state: ack rises the cycle after the request, then drops
   assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign busWr  = busReq & wb_we_i;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `BD_RST_WORD;
      end else begin
         wb_ack_o <= busReq;
         if (busReq) begin
            wb_dat_o <= nxt_rdData;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         packCfg_ff  <= `BD_RST_PACKCFG;
         charge_ff   <= `BD_RST_WORD;
         capacity_ff <= `BD_RST_WORD;
         flags_ff    <= `BD_RST_WORD;
         fullRef_ff  <= `BD_RST_WORD;
      end else if (busWr) begin
         case (wb_adr_i)
            `BD_ADR_PACKCFG: begin
               packCfg_ff <= merge(packCfg_ff, wb_dat_i, wb_sel_i);
            end
            `BD_ADR_CHARGE: begin
               charge_ff <= merge(charge_ff, wb_dat_i, wb_sel_i);
            end
            `BD_ADR_CAPACITY: begin
               capacity_ff <= merge(capacity_ff, wb_dat_i, wb_sel_i);
            end
            `BD_ADR_FLAGS: begin
               flags_ff <= merge(flags_ff, wb_dat_i, wb_sel_i);
            end
            `BD_ADR_FULLREF: begin
               fullRef_ff <= merge(fullRef_ff, wb_dat_i, wb_sel_i);
            end
            default: begin
               flags_ff <= flags_ff;
            end
         endcase
      end
   end

   // Unmapped and read-only writes are acknowledged and dropped
   always @* begin
      nxt_rdData = `BD_RST_WORD;
      case (wb_adr_i)
         `BD_ADR_PACKCFG:  nxt_rdData = packCfg_ff;
         `BD_ADR_CHARGE:   nxt_rdData = charge_ff;
         `BD_ADR_CAPACITY: nxt_rdData = capacity_ff;
         `BD_ADR_FLAGS:    nxt_rdData = flags_ff;
         `BD_ADR_FULLREF:  nxt_rdData = fullRef_ff;
         `BD_ADR_SELREF:   nxt_rdData = {8'h00, percent, refCapacity};
         `BD_ADR_STATUS: begin
            nxt_rdData[`BD_ST_ACTIVE_BIT] = active_ff;
            nxt_rdData[`BD_ST_LOWCAP_BIT] = lowCap;
            nxt_rdData[`BD_ST_PHASE_BIT]  = blinkPhase_ff;
            nxt_rdData[`BD_ST_EOD_BIT]    = eodFlag;
            nxt_rdData[`BD_ST_LED_LO +: SEG_MAX] = ledSeg;
         end
         default: nxt_rdData = `BD_RST_WORD;
      endcase
   end

   // ------------------------------------------------------------
   // Request pin
   // ------------------------------------------------------------
   bd_pin_sync uReqSync (
      .clk      (clk),
      .rst_n    (rst_n),
      .pinIn    (displayRequest_n),
      .levelOut (reqLevel)
   );

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reqLevel_ff <= 1'b1;
      end else begin
         reqLevel_ff <= reqLevel;
      end
   end

   assign fallEdge = reqLevel_ff & ~reqLevel;

   // ------------------------------------------------------------
   // Display timer
   // ------------------------------------------------------------
   // A fall while the timer runs is simply lost, so the button must
   // be released and pressed again after expiry
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_ff  <= 1'b0;
         dispTmr_ff <= {TMR_W{1'b0}};
      end else if (!active_ff) begin
         if (fallEdge) begin
            active_ff  <= 1'b1;
            dispTmr_ff <= DISPLAY_REQUEST_INPUT_LAST;
         end
      end else if (dispTmr_ff == {TMR_W{1'b0}}) begin
         active_ff <= 1'b0;
      end else begin
         dispTmr_ff <= dispTmr_ff - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Blink phase
   // ------------------------------------------------------------
   // Free running so every blink period is equal, even mid-display
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blinkTmr_ff   <= {TMR_W{1'b0}};
         blinkPhase_ff <= 1'b1;
      end else if (blinkTmr_ff == {TMR_W{1'b0}}) begin
         blinkTmr_ff   <= BLINK_LAST;
         blinkPhase_ff <= ~blinkPhase_ff;
      end else begin
         blinkTmr_ff <= blinkTmr_ff - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Reference and charge selection
   // ------------------------------------------------------------
   always @* begin
      if (absMode) begin
         percent     = charge_ff[15:8];
         refCapacity = fullRef_ff[31:16];
      end else begin
         percent     = charge_ff[7:0];
         refCapacity = fullRef_ff[15:0];
      end
   end

   // ------------------------------------------------------------
   // Segment count
   // ------------------------------------------------------------
   always @* begin
      litCount = 3'h1;
      case (segCode)
         `BD_SEG_THREE: begin
            if (percent >= `BD_P3_2)      litCount = 3'h3;
            else if (percent >= `BD_P3_1) litCount = 3'h2;
         end
         `BD_SEG_FOUR: begin
            if (percent >= `BD_P4_3)      litCount = 3'h4;
            else if (percent >= `BD_P4_2) litCount = 3'h3;
            else if (percent >= `BD_P4_1) litCount = 3'h2;
         end
         default: begin
            if (percent >= `BD_P5_4)      litCount = 3'h5;
            else if (percent >= `BD_P5_3) litCount = 3'h4;
            else if (percent >= `BD_P5_2) litCount = 3'h3;
            else if (percent >= `BD_P5_1) litCount = 3'h2;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Segment drive
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < SEG_MAX; g = g + 1) begin : gSeg
         always @* begin
            nxt_ledSeg[g] = active_ff & ~eodFlag
                            & (litCount > g)
                            & (~lowCap | blinkPhase_ff);
         end
      end
   endgenerate

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ledSeg <= {SEG_MAX{1'b0}};
      end else begin
         ledSeg <= nxt_ledSeg;
      end
   end

endmodule // bd_bar_display

`default_nettype wire

// *** verification/bd_bar_props.sv ***
/*
 Port-level checks of the capacity bar display.
 Assumes registers change only through the Wishbone port.
*/
`default_nettype none
`include "bd_defs.vh"
module bd_bar_props #(
   parameter int DISPLAY_REQUEST_INPUT_CYCLES = 200
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Pin and segments
   input wire logic        displayRequest_n,
   input wire logic [4:0]  ledSeg
);
   logic        eodShadow_ff;
   logic [2:0]  cfgShadow_ff;
   logic        pinPrev_ff;
   logic [31:0] sinceFall_ff;
   wire logic   takeWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire logic   mapped = wb_adr_i inside {`BD_ADR_CHARGE, `BD_ADR_CAPACITY, `BD_ADR_FLAGS,
      `BD_ADR_STATUS, `BD_ADR_FULLREF, `BD_ADR_SELREF, `BD_ADR_PACKCFG};
   wire logic [4:0] segMask = (cfgShadow_ff[2:1] == `BD_SEG_THREE) ? 5'h07 :
                              (cfgShadow_ff[2:1] == `BD_SEG_FOUR) ? 5'h0F : 5'h1F;

   // Saturating, so a long idle never wraps into a false press
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eodShadow_ff <= 1'b0;
         cfgShadow_ff <= 3'h4;
         pinPrev_ff   <= 1'b1;
         sinceFall_ff <= 32'hFFFFFFFF;
      end else begin
         pinPrev_ff <= displayRequest_n;
         if (takeWr && wb_adr_i == `BD_ADR_FLAGS)
            eodShadow_ff <= wb_dat_i[0];
         if (takeWr && wb_adr_i == `BD_ADR_PACKCFG)
            cfgShadow_ff <= wb_dat_i[2:0];
         if (pinPrev_ff && !displayRequest_n)
            sinceFall_ff <= 32'h00000000;
         else if (sinceFall_ff != 32'hFFFFFFFF)
            sinceFall_ff <= sinceFall_ff + 32'h00000001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_BAR_FROM_LED1: assert property ((ledSeg & (ledSeg + 5'h01)) == 5'h00)
      else $error("lit segments not a bar from the first");
   AST_SEG_COUNT: assert property ($stable(cfgShadow_ff) |-> (ledSeg & ~segMask) == 5'h00)
      else $error("segment beyond configured count lit");
   AST_EOD_DARK: assert property (eodShadow_ff && $past(eodShadow_ff) |-> ledSeg == 5'h00)
      else $error("segments lit with end of discharge set");
   AST_TIMER_BOUND: assert property (ledSeg != 5'h00 |-> sinceFall_ff <= DISPLAY_REQUEST_INPUT_CYCLES + 12)
      else $error("segments lit without a recent press");
   AST_UNMAPPED_ZERO: assert property (wb_ack_o && !$past(wb_we_i) && !$past(mapped)
      |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   AST_CFG_READBACK: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == `BD_ADR_PACKCFG |-> wb_dat_o[2:0] == cfgShadow_ff)
      else $error("configuration read back wrong");
endmodule // bd_bar_props

bind bd_bar_display bd_bar_props #(.DISPLAY_REQUEST_INPUT_CYCLES(DISPLAY_REQUEST_INPUT_CYCLES)) props_u (
   .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .displayRequest_n(displayRequest_n),
   .ledSeg(ledSeg));
`default_nettype wire

// *** verification/bd_button_model.sv ***
/*
 Pushbutton with pull-up on the display request pin.
 Assumes press is called from one process at a time.
*/
`default_nettype none
module bd_button_model (
   // Clock
   input  wire logic clk,
   // Request pin, pulled up while released
   output var  logic displayRequest_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial displayRequest_n = 1'b1;
   task automatic press(input int holdCyc);
      @(posedge clk);
      displayRequest_n <= 1'b0;
      repeat (holdCyc) @(posedge clk);
      displayRequest_n <= 1'b1;
   endtask
endmodule // bd_button_model
`default_nettype wire

// *** verification/testbench.sv ***
/*
 Self-checking bench of the capacity bar display.
 Assumes bd_defs.vh on the include path; timer shortened to 200 cycles.
*/
`default_nettype none
`include "bd_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DISPLAY_REQUEST_INPUT = 200;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wbCyc = 1'b0;
   logic        wbStb = 1'b0;
   logic [3:0]  wbSel = 4'hF;
   logic        wbWe = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [31:0] wbDatW = 32'h00000000;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic        btnPin;
   logic [4:0]  ledSeg;
   int          bad_count = 0;
   int          tests_run = 0;
   int          pcts[20] = '{0, 19, 20, 24, 25, 33, 34, 39, 40, 49, 50, 59, 60, 66, 67, 74,
                             75, 79, 80, 100};
   always #5 clk = ~clk;
   bd_bar_display #(.DISPLAY_REQUEST_INPUT_CYCLES(DISPLAY_REQUEST_INPUT), .BLINK_CYCLES(16)) dut_u (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .displayRequest_n(btnPin), .ledSeg(ledSeg));
   bd_button_model btn_u (.clk(clk), .displayRequest_n(btnPin));

   task automatic print_verdict();
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic checkLeds(input logic [4:0] exp);
      @(negedge clk);
      tests_run++;
      if (ledSeg !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, ledSeg, exp);
      end
   endtask
   // One classic cycle; waits for ack, bounded
   task automatic busCycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatW <= d;
      // Ack and data are settled mid-cycle; release follows the next rising edge
      do begin
         @(negedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         print_verdict();
      end
      q = wbDatR;
      @(posedge clk);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic wrWord(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      busCycle(1'b1, a, d, q);
      repeat (2) @(posedge clk);
   endtask
   task automatic rdCheck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      busCycle(1'b0, a, 32'h00000000, q);
      checkWord(q & m, e);
   endtask
   task automatic measureLit(output int n);
      n = 0;
      for (int w = 0; w < 30 && ledSeg === 5'h00; w++) @(negedge clk);
      while (ledSeg !== 5'h00 && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask
   function automatic logic [4:0] expBar(int p, int code);
      int n;
      if (code == 0)
         n = 1 + (p >= 34) + (p >= 67);
      else if (code == 1)
         n = 1 + (p >= 25) + (p >= 50) + (p >= 75);
      else
         n = 1 + (p >= 20) + (p >= 40) + (p >= 60) + (p >= 80);
      return 5'((1 << n) - 1);
   endfunction

   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   initial begin
      int n;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rdCheck(`BD_ADR_PACKCFG, 32'hFFFFFFFF, `BD_RST_PACKCFG);
      wbSel <= 4'h0;
      wrWord(`BD_ADR_PACKCFG, 32'h00000001);
      wbSel <= 4'hF;
      rdCheck(`BD_ADR_PACKCFG, 32'hFFFFFFFF, `BD_RST_PACKCFG);
      wrWord(8'h3C, 32'hFFFFFFFF);
      rdCheck(8'h3C, 32'hFFFFFFFF, 32'h00000000);
      checkLeds(5'h00);
      wrWord(`BD_ADR_CAPACITY, 32'h00100100);
      wrWord(`BD_ADR_FULLREF, 32'h12340ABC);
      for (int c = 0; c < 3; c++)
         for (int m = 0; m < 2; m++) begin
            wrWord(`BD_ADR_PACKCFG, {29'h0, c[1:0], m[0]});
            rdCheck(`BD_ADR_SELREF, 32'h0000FFFF, m ? 32'h1234 : 32'h0ABC);
            btn_u.press(3);
            for (int i = 0; i < 20; i++) begin
               wrWord(`BD_ADR_CHARGE, m ? {16'h0, 8'(pcts[i]), 8'(100 - pcts[i])}
                                        : {16'h0, 8'(100 - pcts[i]), 8'(pcts[i])});
               checkLeds(expBar(pcts[i], c));
            end
            for (int w = 0; w < 300 && ledSeg !== 5'h00; w++) @(posedge clk);
            checkLeds(5'h00);
         end
      // Second press while lit must not stretch the display
      fork
         begin
            btn_u.press(3);
            repeat (60) @(posedge clk);
            btn_u.press(3);
         end
         measureLit(n);
      join
      checkWord(n, DISPLAY_REQUEST_INPUT);
      fork
         btn_u.press(300);
         measureLit(n);
      join
      checkWord(n, DISPLAY_REQUEST_INPUT);
      checkLeds(5'h00);
      repeat (5) @(posedge clk);
      btn_u.press(3);
      repeat (4) @(posedge clk);
      checkLeds(5'h1F);
      wrWord(`BD_ADR_FLAGS, 32'h00000001);
      checkLeds(5'h00);
      wrWord(`BD_ADR_FLAGS, 32'h00000000);
      checkLeds(5'h1F);
      wrWord(`BD_ADR_CAPACITY, 32'h02000100);
      n = 0;
      repeat (40) begin
         @(negedge clk);
         n += (ledSeg === 5'h1F);
      end
      checkWord(n > 0 && n < 40, 32'h00000001);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
